// ==== design/mcs_pkg.sv ====
/*
 multichannel selection control: shared constants, field positions,
 register offsets and mode types.
 assumes a 32-bit apb register bus on pclk and 128 serial channels.
*/
`default_nettype none
package mcs_pkg;
   localparam int ADDR_W    = 12;
   localparam int DATA_W    = 32;
   localparam int STRB_W    = 4;
   localparam int CHANS     = 128;
   localparam int CH_W      = 7;
   localparam int BLK_W     = 3;
   localparam int PBLK_W    = 2;
   localparam int EN_REGS   = 4;
   localparam int EN_IDX_W  = 2;

   localparam logic [ADDR_W-1:0] CTRL_OFFSET    = 12'h000;
   localparam logic [ADDR_W-1:0] RX_ENABLE_BASE = 12'h010;
   localparam logic [ADDR_W-1:0] TX_ENABLE_BASE = 12'h020;

   localparam int TX_PART_MODE_BIT = 25;
   localparam int TX_B_LO          = 23;
   localparam int TX_A_LO          = 21;
   localparam int TX_CUR_LO        = 18;
   localparam int TX_SEL_LO        = 16;
   localparam int RX_PART_MODE_BIT = 9;
   localparam int RX_B_LO          = 7;
   localparam int RX_A_LO          = 5;
   localparam int RX_CUR_LO        = 2;
   localparam int RX_SEL_BIT       = 0;

   localparam logic [DATA_W-1:0] CTRL_RESET   = 32'h0000_0000;
   localparam logic [DATA_W-1:0] ENABLE_RESET = 32'h0000_0000;
   localparam logic [PBLK_W-1:0] PBLK_RESET   = 2'h0;
   localparam logic [BLK_W-1:0]  BLK_RESET    = 3'h0;

   typedef enum logic [1:0] {
      SEL_ALL       = 2'h0,
      SEL_ONLY      = 2'h1,
      SEL_MASKED    = 2'h2,
      SEL_SYMMETRIC = 2'h3
   } select_mode_type;

   typedef enum {APB_IDLE, APB_ANSWER} apb_state_type;
endpackage
`default_nettype wire

// ==== design/channel_gate_if.sv ====
/*
 carrier between the register bank and one channel gate.
 assumes both ends sit on the same pclk.
*/
`default_nettype none
interface channel_gate_if;
   import mcs_pkg::*;
   select_mode_type          select_mode;
   logic                     partition_mode;
   logic [PBLK_W-1:0]        part_a_block;
   logic [PBLK_W-1:0]        part_b_block;
   logic [PBLK_W-1:0]        alt_a_block;
   logic [PBLK_W-1:0]        alt_b_block;
   logic [CHANS-1:0]         enable_bits;
   logic [CHANS-1:0]         alt_enable_bits;
   logic [CH_W-1:0]          channel_index;
   logic                     channel_valid;
   logic                     channel_enable;
   logic                     channel_unmasked;
   logic [BLK_W-1:0]         current_block;

   modport bank (output select_mode, partition_mode, part_a_block, part_b_block,
                 alt_a_block, alt_b_block, enable_bits, alt_enable_bits,
                 channel_index, channel_valid,
                 input channel_enable, channel_unmasked, current_block);
   modport gate (input select_mode, partition_mode, part_a_block, part_b_block,
                 alt_a_block, alt_b_block, enable_bits, alt_enable_bits,
                 channel_index, channel_valid,
                 output channel_enable, channel_unmasked, current_block);
endinterface
`default_nettype wire

// ==== design/channel_gate.sv ====
/*
 channel gate: decides per serial channel whether it is enabled and
 unmasked, and tracks the block in use.
 assumes channel_index comes from framing logic on pclk.
*/
`default_nettype none
module channel_gate (
   input  wire logic   pclk,
   input  wire logic   presetn,
   channel_gate_if.gate g
);
   import mcs_pkg::*;

   function automatic logic in_partitions(input logic [BLK_W-1:0]  blk,
                                          input logic [PBLK_W-1:0] a,
                                          input logic [PBLK_W-1:0] b);
      // partition a takes even blocks, partition b odd ones
      in_partitions = (blk == {a, 1'b0}) || (blk == {b, 1'b1});
   endfunction

   wire logic [BLK_W-1:0] blk_now   = g.channel_index[CH_W-1:CH_W-BLK_W];
   wire logic             own_bit   = g.enable_bits[g.channel_index];
   wire logic             alt_bit   = g.alt_enable_bits[g.channel_index];
   wire logic             symmetric = (g.select_mode == SEL_SYMMETRIC);
   wire logic [PBLK_W-1:0] use_a    = symmetric ? g.alt_a_block : g.part_a_block;
   wire logic [PBLK_W-1:0] use_b    = symmetric ? g.alt_b_block : g.part_b_block;
   wire logic             reach     = g.partition_mode || in_partitions(blk_now, use_a, use_b);
   wire logic             own_sel   = reach && own_bit;
   wire logic             alt_sel   = reach && alt_bit;
   logic                  enable_next;
   logic                  unmask_next;

   always_comb begin
      unique case (g.select_mode)
         SEL_ALL: begin
            enable_next = 1'b1;
            unmask_next = 1'b1;
         end
         SEL_ONLY: begin
            enable_next = own_sel;
            unmask_next = own_sel;
         end
         SEL_MASKED: begin
            enable_next = 1'b1;
            unmask_next = own_sel;
         end
         SEL_SYMMETRIC: begin
            enable_next = alt_sel;
            unmask_next = own_sel;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         g.channel_enable   <= 1'b0;
         g.channel_unmasked <= 1'b0;
         g.current_block    <= BLK_RESET;
      end else if (g.channel_valid) begin
         g.channel_enable   <= enable_next;
         g.channel_unmasked <= unmask_next;
         g.current_block    <= blk_now;
      end
   end
endmodule
`default_nettype wire

// ==== design/multichannel_select_control.sv ====
/*
 multichannel selection control register bank with apb slave, the
 rx and tx enhanced channel-enable registers and two channel gates.
 assumes framing logic on pclk presents channel index with a valid
 strobe per channel, and an apb4 master on pclk.
*/
// Design decisions made here: register access over APB and the register offsets.
`default_nettype none
module multichannel_select_control (
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [mcs_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [mcs_pkg::DATA_W-1:0]   pwdata,
   input  wire logic [mcs_pkg::STRB_W-1:0]   pstrb,
   output var  logic [mcs_pkg::DATA_W-1:0]   prdata,
   output var  logic                         pready,
   output var  logic                         pslverr,
   input  wire logic [mcs_pkg::CH_W-1:0]     rx_channel_index,
   input  wire logic                         rx_channel_valid,
   input  wire logic [mcs_pkg::CH_W-1:0]     tx_channel_index,
   input  wire logic                         tx_channel_valid,
   output var  logic                         rx_channel_enable,
   output var  logic                         tx_channel_enable,
   output var  logic                         tx_channel_unmasked
);
   import mcs_pkg::*;

   // address decoding used for both read and write paths
   function automatic logic is_ctrl(input logic [ADDR_W-1:0] a);
      is_ctrl = (a == CTRL_OFFSET);
   endfunction

   function automatic logic in_bank(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] base);
      in_bank = (a[ADDR_W-1:4] == base[ADDR_W-1:4]) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic [EN_IDX_W-1:0] bank_index(input logic [ADDR_W-1:0] a);
      bank_index = a[3:2];
   endfunction

   function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old,
                                                    input logic [DATA_W-1:0] wd,
                                                    input logic [STRB_W-1:0] st);
      lane_merge = old;
      for (int i = 0; i < STRB_W; i++) begin
         if (st[i]) begin
            lane_merge[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
   endfunction

   // apb handshake: one wait state, answer registered
   apb_state_type state_reg;
   apb_state_type state_next;

   wire logic access    = psel && penable;
   wire logic take      = (state_reg == APB_ANSWER);
   wire logic hit_ctrl  = is_ctrl(paddr);
   wire logic hit_rx    = in_bank(paddr, RX_ENABLE_BASE);
   wire logic hit_tx    = in_bank(paddr, TX_ENABLE_BASE);
   wire logic mapped    = hit_ctrl || hit_rx || hit_tx;
   wire logic do_write  = take && pwrite && mapped;
   wire logic wr_ctrl   = do_write && hit_ctrl;
   wire logic wr_rx     = do_write && hit_rx;
   wire logic wr_tx     = do_write && hit_tx;
   wire logic [EN_IDX_W-1:0] widx = bank_index(paddr);

   always_comb begin
      unique case (state_reg)
         APB_IDLE:   state_next = access ? APB_ANSWER : APB_IDLE;
         APB_ANSWER: state_next = APB_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= APB_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // writable control fields of the multichannel selection control
   logic                     rx_channel_select_mode;
   logic                     rx_partition_mode;
   logic [PBLK_W-1:0]        rx_part_a_block;
   logic [PBLK_W-1:0]        rx_part_b_block;
   select_mode_type          tx_channel_select_mode;
   logic                     tx_partition_mode;
   logic [PBLK_W-1:0]        tx_part_a_block;
   logic [PBLK_W-1:0]        tx_part_b_block;

   // merged word after byte lanes; only writable fields are taken from it
   wire logic [DATA_W-1:0] ctrl_view;
   wire logic [DATA_W-1:0] ctrl_wr = lane_merge(ctrl_view, pwdata, pstrb);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_channel_select_mode <= 1'b0;
         rx_partition_mode      <= 1'b0;
         rx_part_a_block        <= PBLK_RESET;
         rx_part_b_block        <= PBLK_RESET;
         tx_channel_select_mode <= SEL_ALL;
         tx_partition_mode      <= 1'b0;
         tx_part_a_block        <= PBLK_RESET;
         tx_part_b_block        <= PBLK_RESET;
      end else if (wr_ctrl) begin
         rx_channel_select_mode <= ctrl_wr[RX_SEL_BIT];
         rx_partition_mode      <= ctrl_wr[RX_PART_MODE_BIT];
         rx_part_a_block        <= ctrl_wr[RX_A_LO +: PBLK_W];
         rx_part_b_block        <= ctrl_wr[RX_B_LO +: PBLK_W];
         tx_channel_select_mode <= select_mode_type'(ctrl_wr[TX_SEL_LO +: 2]);
         tx_partition_mode      <= ctrl_wr[TX_PART_MODE_BIT];
         tx_part_a_block        <= ctrl_wr[TX_A_LO +: PBLK_W];
         tx_part_b_block        <= ctrl_wr[TX_B_LO +: PBLK_W];
      end
   end

   // enhanced channel-enable registers, four per side
   logic [DATA_W-1:0] rx_enhanced_channel_enable [EN_REGS];
   logic [DATA_W-1:0] tx_enhanced_channel_enable [EN_REGS];
   wire  logic [CHANS-1:0] rx_enable_flat;
   wire  logic [CHANS-1:0] tx_enable_flat;

   genvar n;
   generate
      for (n = 0; n < EN_REGS; n++) begin : g_enable
         wire logic wr_rx_n = wr_rx && (widx == EN_IDX_W'(n));
         wire logic wr_tx_n = wr_tx && (widx == EN_IDX_W'(n));

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               rx_enhanced_channel_enable[n] <= ENABLE_RESET;
            end else if (wr_rx_n) begin
               rx_enhanced_channel_enable[n] <= lane_merge(rx_enhanced_channel_enable[n],
                                                           pwdata, pstrb);
            end
         end

         // tx register n covers channels 32n to 32n+31
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               tx_enhanced_channel_enable[n] <= ENABLE_RESET;
            end else if (wr_tx_n) begin
               tx_enhanced_channel_enable[n] <= lane_merge(tx_enhanced_channel_enable[n],
                                                           pwdata, pstrb);
            end
         end

         assign rx_enable_flat[n*DATA_W +: DATA_W] = rx_enhanced_channel_enable[n];
         assign tx_enable_flat[n*DATA_W +: DATA_W] = tx_enhanced_channel_enable[n];
      end
   endgenerate

   // channel gates; rx is never masked, so it only uses select-all or select-only mode
   channel_gate_if rx_link ();
   channel_gate_if tx_link ();

   wire logic [BLK_W-1:0] rx_current_block = rx_link.current_block;
   wire logic [BLK_W-1:0] tx_current_block = tx_link.current_block;

   assign rx_link.select_mode     = rx_channel_select_mode ? SEL_ONLY : SEL_ALL;
   assign rx_link.partition_mode  = rx_partition_mode;
   assign rx_link.part_a_block    = rx_part_a_block;
   assign rx_link.part_b_block    = rx_part_b_block;
   assign rx_link.alt_a_block     = rx_part_a_block;
   assign rx_link.alt_b_block     = rx_part_b_block;
   assign rx_link.enable_bits     = rx_enable_flat;
   assign rx_link.alt_enable_bits = rx_enable_flat;
   assign rx_link.channel_index   = rx_channel_index;
   assign rx_link.channel_valid   = rx_channel_valid;

   // partition mode only matters under individual control
   assign tx_link.select_mode     = tx_channel_select_mode;
   assign tx_link.partition_mode  = tx_partition_mode;
   assign tx_link.part_a_block    = tx_part_a_block;
   assign tx_link.part_b_block    = tx_part_b_block;
   assign tx_link.alt_a_block     = rx_part_a_block;
   assign tx_link.alt_b_block     = rx_part_b_block;
   assign tx_link.enable_bits     = tx_enable_flat;
   assign tx_link.alt_enable_bits = rx_enable_flat;
   assign tx_link.channel_index   = tx_channel_index;
   assign tx_link.channel_valid   = tx_channel_valid;

   channel_gate rx_gate (
      .pclk    (pclk),
      .presetn (presetn),
      .g       (rx_link.gate)
   );

   channel_gate tx_gate (
      .pclk    (pclk),
      .presetn (presetn),
      .g       (tx_link.gate)
   );

   assign rx_channel_enable   = rx_link.channel_enable;
   assign tx_channel_enable   = tx_link.channel_enable;
   assign tx_channel_unmasked = tx_link.channel_unmasked;

   // register image; reserved and status bits not writable
   wire logic [DATA_W-1:0] ctrl_reserved_zero = CTRL_RESET;
   assign ctrl_view = ctrl_reserved_zero
                   | (DATA_W'(tx_partition_mode)      << TX_PART_MODE_BIT)
                   | (DATA_W'(tx_part_b_block)        << TX_B_LO)
                   | (DATA_W'(tx_part_a_block)        << TX_A_LO)
                   | (DATA_W'(tx_current_block)       << TX_CUR_LO)
                   | (DATA_W'(tx_channel_select_mode) << TX_SEL_LO)
                   | (DATA_W'(rx_partition_mode)      << RX_PART_MODE_BIT)
                   | (DATA_W'(rx_part_b_block)        << RX_B_LO)
                   | (DATA_W'(rx_part_a_block)        << RX_A_LO)
                   | (DATA_W'(rx_current_block)       << RX_CUR_LO)
                   | (DATA_W'(rx_channel_select_mode) << RX_SEL_BIT);

   wire logic [DATA_W-1:0] rx_bank_word = rx_enhanced_channel_enable[widx];
   wire logic [DATA_W-1:0] tx_bank_word = tx_enhanced_channel_enable[widx];
   wire logic [DATA_W-1:0] read_word    = hit_ctrl ? ctrl_view
                                        : hit_rx  ? rx_bank_word
                                        : hit_tx  ? tx_bank_word
                                        : '0;

   // answer is prepared on entering the access phase, shown with pready and cleared after that cycle
   wire logic enter_answer = (state_reg == APB_IDLE) && access;
   logic [DATA_W-1:0] prdata_next;
   logic              pslverr_next;

   always_comb begin
      prdata_next  = prdata;
      pslverr_next = pslverr;
      if (enter_answer) begin
         prdata_next  = pwrite ? '0 : read_word;
         pslverr_next = !mapped;
      end else if (take) begin
         prdata_next  = '0;
         pslverr_next = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end else begin
         pready  <= enter_answer;
         prdata  <= prdata_next;
         pslverr <= pslverr_next;
      end
   end
endmodule
`default_nettype wire

// ==== testbench/mcs_chk.sv ====
/*
 assertions on the apb and channel ports of the selection bank.
 assumes it is bound to the top module and sees only its ports.
*/
`default_nettype none
module mcs_chk (
   input wire logic                       pclk,
   input wire logic                       presetn,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [mcs_pkg::ADDR_W-1:0] paddr,
   input wire logic [mcs_pkg::DATA_W-1:0] prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire logic [mcs_pkg::CH_W-1:0]   rx_channel_index,
   input wire logic                       rx_channel_valid,
   input wire logic [mcs_pkg::CH_W-1:0]   tx_channel_index,
   input wire logic                       tx_channel_valid,
   input wire logic                       rx_channel_enable,
   input wire logic                       tx_channel_enable,
   input wire logic                       tx_channel_unmasked
);
   import mcs_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic [BLK_W-1:0] rx_blk_reg;
   logic [BLK_W-1:0] tx_blk_reg;
   wire              rd_ctrl = pready && !pwrite && paddr == CTRL_OFFSET;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // last block seen on each side
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_blk_reg <= BLK_RESET;
         tx_blk_reg <= BLK_RESET;
      end else begin
         if (rx_channel_valid) rx_blk_reg <= rx_channel_index[6:4];
         if (tx_channel_valid) tx_blk_reg <= tx_channel_index[6:4];
      end
   end
   sequence access_begin;
      psel && penable && !$past(penable);
   endsequence
   sequence one_wait;
      !pready ##1 pready;
   endsequence
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   wait_state_a: assert property (access_begin |-> one_wait)
      else $error("access not answered after one wait state");
   rdata_idle_a: assert property (!pready |-> prdata == '0)
      else $error("prdata nonzero outside answer");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   unmapped_err_a: assert property (psel && pready && paddr[11:6] != 6'h0 |-> pslverr)
      else $error("unmapped address not refused");
   reserved_zero_a: assert property (rd_ctrl |-> prdata[31:26] == 6'h0 &&
      prdata[15:10] == 6'h0 && !prdata[1] && !pslverr)
      else $error("reserved control bits not zero");
   rx_block_a: assert property (rd_ctrl && !$past(rx_channel_valid) &&
      !$past(rx_channel_valid, 2) |-> prdata[4:2] == rx_blk_reg)
      else $error("rx current block wrong");
   tx_block_a: assert property (rd_ctrl && !$past(tx_channel_valid) &&
      !$past(tx_channel_valid, 2) |-> prdata[20:18] == tx_blk_reg)
      else $error("tx current block wrong");
   tx_hold_a: assert property (!$past(tx_channel_valid) |->
      $stable(tx_channel_enable) && $stable(tx_channel_unmasked))
      else $error("tx gate changed without strobe");
   rx_hold_a: assert property (!$past(rx_channel_valid) |-> $stable(rx_channel_enable))
      else $error("rx gate changed without strobe");
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
/*
 self-checking bench for the selection bank: apb access, fields, gating.
 assumes the design package and the checker are compiled first.
*/
`default_nettype none
module testbench;
   import mcs_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic                pclk = 0;
   logic                presetn = 0;
   logic                psel = 0;
   logic                penable = 0;
   logic                pwrite = 0;
   logic [ADDR_W-1:0]   paddr = '0;
   logic [DATA_W-1:0]   pwdata = '0;
   logic [STRB_W-1:0]   pstrb = 4'hf;
   logic [DATA_W-1:0]   prdata;
   logic                pready, pslverr;
   logic [CH_W-1:0]     rx_idx = '0;
   logic [CH_W-1:0]     tx_idx = '0;
   logic                rx_val = 0;
   logic                tx_val = 0;
   logic                rx_en, tx_en, tx_unm;
   int                  err_count = 0;
   int                  n_compared = 0;
   multichannel_select_control multichannel_select_control_i (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_channel_index(rx_idx), .rx_channel_valid(rx_val),
      .tx_channel_index(tx_idx), .tx_channel_valid(tx_val), .rx_channel_enable(rx_en),
      .tx_channel_enable(tx_en), .tx_channel_unmasked(tx_unm));
   always #20 pclk = ~pclk;
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      if (n >= 20) chk(32'h0, 32'h1, "no pready");
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
      chk({31'h0, e}, 32'h0, "write error");
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, x, "read data");
      chk({31'h0, e}, {31'h0, xe}, "read error");
   endtask
   // one strobe; rx compares {enable,0}, tx compares {enable,unmasked}
   task automatic ch(input logic tx, input logic [6:0] i, input logic [1:0] x);
      @(posedge pclk);
      if (tx) tx_val <= 1;
      else rx_val <= 1;
      tx_idx <= i;
      rx_idx <= i;
      @(posedge pclk);
      tx_val <= 0;
      rx_val <= 0;
      @(posedge pclk);
      chk({30'h0, tx ? {tx_en, tx_unm} : {rx_en, 1'b0}}, {30'h0, x}, "gate");
   endtask
   task automatic t_map;
      rd(CTRL_OFFSET, 32'h0, 0);
      rd(RX_ENABLE_BASE + 12'h00c, 32'h0, 0);
      rd(TX_ENABLE_BASE, 32'h0, 0);
      rd(12'h100, 32'h0, 1);
      $display("test map done");
   endtask
   task automatic t_fields;
      wr(CTRL_OFFSET, 32'hffff_ffff);
      rd(CTRL_OFFSET, 32'h03e3_03e1, 0);
      wr(CTRL_OFFSET, 32'h0);
      rd(CTRL_OFFSET, 32'h0, 0);
      ch(0, 7'h35, 2'b10);
      ch(1, 7'h62, 2'b11);
      rd(CTRL_OFFSET, 32'h0018_000c, 0);
      $display("test fields done");
   endtask
   // eight partitions, modes 0..3: channel 32 selected, channel 33 not
   task automatic t_eight;
      logic [3:0] e32 = 4'b0111;
      logic [3:0] e33 = 4'b0101;
      logic [3:0] u33 = 4'b0001;
      wr(TX_ENABLE_BASE + 12'h004, 32'h0000_0001);
      for (int m = 0; m < 4; m++) begin
         wr(CTRL_OFFSET, 32'h0200_0000 | (m << 16));
         ch(1, 7'd32, {e32[m], 1'b1});
         ch(1, 7'd33, {e33[m], u33[m]});
      end
      $display("test eight done");
   endtask
   task automatic t_two;
      for (int k = 0; k < 4; k++) wr(TX_ENABLE_BASE + 12'(4 * k), 32'hffff_ffff);
      wr(CTRL_OFFSET, 32'h0121_0000);
      ch(1, 7'd40, 2'b11);
      ch(1, 7'd85, 2'b11);
      ch(1, 7'd0, 2'b00);
      ch(1, 7'd48, 2'b00);
      wr(CTRL_OFFSET, 32'h0020_0000);
      ch(1, 7'd0, 2'b11);
      $display("test two done");
   endtask
   task automatic t_sym;
      for (int k = 0; k < 4; k++) wr(RX_ENABLE_BASE + 12'(4 * k), 32'hffff_ffff);
      wr(CTRL_OFFSET, 32'h0183_0040);
      ch(1, 7'd70, 2'b11);
      ch(1, 7'd112, 2'b00);
      $display("test sym done");
   endtask
   task automatic t_rx;
      wr(CTRL_OFFSET, 32'h0000_0001);
      ch(0, 7'd20, 2'b10);
      ch(0, 7'd40, 2'b00);
      wr(CTRL_OFFSET, 32'h0000_0201);
      ch(0, 7'd40, 2'b10);
      wr(RX_ENABLE_BASE + 12'h004, 32'h0);
      ch(0, 7'd40, 2'b00);
      wr(CTRL_OFFSET, 32'h0000_0200);
      ch(0, 7'd40, 2'b10);
      $display("test rx done");
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      t_map();
      t_fields();
      t_eight();
      t_two();
      t_sym();
      t_rx();
      close_out();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      close_out();
   end
endmodule
bind multichannel_select_control mcs_chk mcs_chk_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .rx_channel_index(rx_channel_index),
   .rx_channel_valid(rx_channel_valid), .tx_channel_index(tx_channel_index),
   .tx_channel_valid(tx_channel_valid), .rx_channel_enable(rx_channel_enable),
   .tx_channel_enable(tx_channel_enable), .tx_channel_unmasked(tx_channel_unmasked));
`default_nettype wire
